// file: design/scs_pkg.sv
// Package for the slow clock select block: register map, field layout, reset values.
// Assumes a 32-bit register port and one 125 MHz system clock.
package scs_pkg;
  localparam logic [31:0] SCS_CTRL_ADDR   = 32'h0ffffd50;
  localparam int          SCS_RC_EN_BIT   = 0;
  localparam int          SCS_XT_EN_BIT   = 1;
  localparam int          SCS_SEL_BIT     = 3;
  localparam int          SCS_BYP_BIT     = 2;
  localparam int          SCS_ACT_BIT     = 4;
  localparam logic        SCS_RC_EN_RST   = 1'h1;
  localparam logic        SCS_XT_EN_RST   = 1'h0;
  localparam logic        SCS_SEL_RST     = 1'h0;
  localparam logic        SCS_BYP_RST     = 1'h0;
  localparam int          SCS_SYNC_STAGES = 2;
  localparam logic [2:0]  SCS_SETTLE_CYC  = 3'h4;
  typedef enum logic [1:0] {SCS_ON_RC, SCS_TO_XT, SCS_ON_XT, SCS_TO_RC} scs_state_t;
endpackage

// file: design/scs_sel_if.sv
// Interface carrying the requested source from the control logic to the clock mux.
// Assumes both ends share clk.
`timescale 1ns/1ps
`default_nettype none
interface scs_sel_if;
  logic req_sel;
  logic req_byp;
  logic act_sel;
  modport ctrl (output req_sel, output req_byp, input act_sel);
  modport mux  (input req_sel, input req_byp, output act_sel);
endinterface
`default_nettype wire

// file: design/scs_mux.sv
// Glitch-free source switch: the selection is resynchronised before the mux moves.
// Assumes the oscillator outputs are sampled as levels on clk.
`timescale 1ns/1ps
`default_nettype none
module scs_mux
  import scs_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic rc_clk_in,
  input  wire logic xt_clk_in,
  input  wire logic slow_xtal_input,
  scs_sel_if.mux    sel,
  output logic      slow_clk
);
  logic [SCS_SYNC_STAGES-1:0] sync_r;
  logic [SCS_SYNC_STAGES-1:0] sync_nxt;
  logic       act_r;
  logic       act_nxt;
  logic       out_r;
  logic       out_nxt;
  logic       xsrc;

  assign xsrc = sel.req_byp ? slow_xtal_input : xt_clk_in;

  always_comb
  begin
    sync_nxt = {sync_r[SCS_SYNC_STAGES-2:0], sel.req_sel};
    act_nxt  = act_r;
    // switch only while both sources low
    if (sync_r[SCS_SYNC_STAGES-1] != act_r && !rc_clk_in && !xsrc)
      act_nxt = sync_r[SCS_SYNC_STAGES-1];
    out_nxt = act_nxt ? xsrc : rc_clk_in;
    if (srst)
    begin
      sync_nxt = '0;
      act_nxt  = SCS_SEL_RST;
      out_nxt  = 1'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    sync_r <= sync_nxt;
    act_r  <= act_nxt;
    out_r  <= out_nxt;
  end

  assign slow_clk    = out_r;
  assign sel.act_sel = act_r;

  property p_sel_sync;
    @(posedge clk) disable iff (srst)
      (act_r != sync_r[SCS_SYNC_STAGES-1] && !rc_clk_in && !xsrc) |=> act_r == $past(sync_r[SCS_SYNC_STAGES-1]);
  endproperty
  a_sel_sync: assert property (p_sel_sync) else $error("mux did not follow select");
endmodule
`default_nettype wire

// file: design/scs_top.sv
// Function
// - Slow clock comes from crystal or RC oscillator per select bit.
// - Bypass bit passes external clock on crystal pin instead of crystal.
// - Each oscillator runs while its enable bit is one.
// - All four bits live in one control register at the documented address.
// - Reset gives RC enabled, crystal off, select RC.
// Top of the slow clock select block with its control register and status.
// Assumes srst is the backup-supply power-on reset and oscillators are outside.
`timescale 1ns/1ps
`default_nettype none
module scs_top
  import scs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  input  wire logic        rc_clk_in,
  input  wire logic        xt_clk_in,
  input  wire logic        slow_xtal_input,
  output logic             rc_osc_enable,
  output logic             slow_xtal_enable,
  output logic             slow_clk,
  output logic             switch_busy
);
  logic        rc_en_r;
  logic        rc_en_nxt;
  logic        xt_en_r;
  logic        xt_en_nxt;
  logic        sel_r;
  logic        sel_nxt;
  logic        byp_r;
  logic        byp_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  scs_state_t  st_r;
  scs_state_t  st_nxt;
  logic        hit;

  scs_sel_if sif ();

  assign hit = addr == SCS_CTRL_ADDR;

  always_comb
  begin
    rc_en_nxt = rc_en_r;
    xt_en_nxt = xt_en_r;
    sel_nxt   = sel_r;
    byp_nxt   = byp_r;
    rdata_nxt = 32'h0;
    if (wr && hit)
    begin
      rc_en_nxt = wdata[SCS_RC_EN_BIT];
      xt_en_nxt = wdata[SCS_XT_EN_BIT];
      sel_nxt   = wdata[SCS_SEL_BIT];
      byp_nxt   = wdata[SCS_BYP_BIT];
    end
    if (rd && hit)
    begin
      rdata_nxt[SCS_RC_EN_BIT] = rc_en_r;
      rdata_nxt[SCS_XT_EN_BIT] = xt_en_r;
      rdata_nxt[SCS_SEL_BIT]   = sel_r;
      rdata_nxt[SCS_BYP_BIT]   = byp_r;
      rdata_nxt[SCS_ACT_BIT]   = sif.act_sel;
    end
    if (srst)
    begin
      rc_en_nxt = SCS_RC_EN_RST;
      xt_en_nxt = SCS_XT_EN_RST;
      sel_nxt   = SCS_SEL_RST;
      byp_nxt   = SCS_BYP_RST;
    end
  end

  always_ff @(posedge clk)
  begin
    rc_en_r <= rc_en_nxt;
    xt_en_r <= xt_en_nxt;
    sel_r   <= sel_nxt;
    byp_r   <= byp_nxt;
    rdata_r <= rdata_nxt;
  end

  // The mux sequences the switch, so the state only reports progress.
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      SCS_ON_RC: if (sel_r) st_nxt = SCS_TO_XT;
      // A select that flips back before the mux follows must not strand the busy flag.
      SCS_TO_XT:
        if (!sel_r)
          st_nxt = SCS_TO_RC;
        else if (sif.act_sel)
          st_nxt = SCS_ON_XT;
      SCS_ON_XT: if (!sel_r) st_nxt = SCS_TO_RC;
      SCS_TO_RC:
        if (sel_r)
          st_nxt = SCS_TO_XT;
        else if (!sif.act_sel)
          st_nxt = SCS_ON_RC;
    endcase
    if (srst)
      st_nxt = SCS_ON_RC;
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  assign sif.req_sel = sel_r;
  assign sif.req_byp = byp_r;

  scs_mux u_mux (
    .clk             (clk),
    .srst            (srst),
    .rc_clk_in       (rc_clk_in),
    .xt_clk_in       (xt_clk_in),
    .slow_xtal_input (slow_xtal_input),
    .sel             (sif.mux),
    .slow_clk        (slow_clk)
  );

  assign rc_osc_enable    = rc_en_r;
  assign slow_xtal_enable = xt_en_r;
  assign switch_busy      = st_r == SCS_TO_XT || st_r == SCS_TO_RC;
  assign rdata            = rdata_r;

  property p_reset_dflt;
    @(posedge clk) srst |=> rc_osc_enable && !slow_xtal_enable && !sel_r;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("bad reset defaults");

  property p_wr_en;
    @(posedge clk) disable iff (srst)
      (wr && hit) |=> rc_osc_enable == $past(wdata[SCS_RC_EN_BIT])
        && slow_xtal_enable == $past(wdata[SCS_XT_EN_BIT]);
  endproperty
  a_wr_en: assert property (p_wr_en) else $error("enable not written");

  property p_hold;
    @(posedge clk) disable iff (srst) !(wr && hit) |=> $stable(sel_r) && $stable(byp_r);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");

  property p_rd;
    @(posedge clk) disable iff (srst)
      (rd && hit) |=> rdata[SCS_SEL_BIT] == $past(sel_r) && rdata[SCS_BYP_BIT] == $past(byp_r);
  endproperty
  a_rd: assert property (p_rd) else $error("readback wrong");

  property p_switch_bound;
    @(posedge clk) disable iff (srst) $rose(sel_r) |-> ##[1:200] sif.act_sel || !sel_r;
  endproperty
  a_switch_bound: assert property (p_switch_bound) else $error("switch never done");

  // Idle or unmapped cycles must read as zero so stale data never reaches software.
  property p_rd_zero;
    @(posedge clk) disable iff (srst)
      !(rd && hit) |=> rdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not cleared");

  property p_rd_en;
    @(posedge clk) disable iff (srst)
      (rd && hit) |=> rdata[SCS_RC_EN_BIT] == $past(rc_en_r)
        && rdata[SCS_XT_EN_BIT] == $past(xt_en_r);
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");

  property p_rd_act;
    @(posedge clk) disable iff (srst)
      (rd && hit) |=> rdata[SCS_ACT_BIT] == $past(sif.act_sel);
  endproperty
  a_rd_act: assert property (p_rd_act) else $error("active select readback wrong");

  property p_wr_sel;
    @(posedge clk) disable iff (srst)
      (wr && hit) |=> sel_r == $past(wdata[SCS_SEL_BIT])
        && byp_r == $past(wdata[SCS_BYP_BIT]);
  endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("select or bypass not written");

  property p_rst_idle;
    @(posedge clk) srst |=> !switch_busy && !sif.act_sel;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset left a switch pending");

  // A new request is reported as busy until the mux has really moved.
  sequence s_go_xt;
    st_r == SCS_ON_RC && sel_r;
  endsequence

  sequence s_go_rc;
    st_r == SCS_ON_XT && !sel_r;
  endsequence

  property p_busy_set;
    @(posedge clk) disable iff (srst)
      s_go_xt or s_go_rc |=> switch_busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not raised on request");

  sequence s_xt_done;
    st_r == SCS_TO_XT && sel_r && sif.act_sel;
  endsequence

  sequence s_rc_done;
    st_r == SCS_TO_RC && !sel_r && !sif.act_sel;
  endsequence

  property p_busy_clr;
    @(posedge clk) disable iff (srst)
      s_xt_done or s_rc_done |=> !switch_busy;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared after switch");
endmodule
`default_nettype wire

// file: tb/tb_scs_top.sv
// Testbench for the slow clock select block: control register, enables, source switching.
// Assumes the register port of scs_top and oscillator levels made from a bench counter.
`timescale 1ns/1ps
`default_nettype none
module tb_scs_top;
  import scs_pkg::*;
  logic        clk;
  logic        srst;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        rc_en;
  logic        xt_en;
  logic        slow_clk;
  logic        busy;
  logic [7:0]  cyc = 8'h00;
  logic [3:0]  src_h = 4'h0;
  logic [1:0]  want;
  int          bad_count;
  int          tests_run;
  wire logic   src = (want == 2'h0) ? cyc[3] : (want == 2'h1) ? cyc[2] : cyc[4];

  scs_top u_dut (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rc_clk_in(cyc[3]), .xt_clk_in(cyc[2]),
    .slow_xtal_input(cyc[4]), .rc_osc_enable(rc_en),
    .slow_xtal_enable(xt_en), .slow_clk(slow_clk), .switch_busy(busy));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc   <= cyc + 8'h01;
    src_h <= {src_h[2:0], src};
  end

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr_reg(input logic [31:0] d);
    @(posedge clk);
    addr  <= SCS_CTRL_ADDR;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk((rdata & m) === e, "read data");
  endtask

  // Compare only once the chosen source has held its level long enough to pass the mux.
  task automatic settle(input logic [1:0] w);
    int n;
    want = w;
    n = 0;
    repeat (2) @(negedge clk);
    while (busy !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk(n < 200, "switch stuck");
    if (n >= 200)
      end_sim();
    repeat (4) @(negedge clk);
    repeat (64)
    begin
      @(negedge clk);
      if (src_h == {4{src}})
        chk(slow_clk === src, "slow clock source");
    end
  endtask

  initial
  begin
    srst = 1'b1;
    addr = 32'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    want = 2'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(rc_en === 1'b1 && xt_en === 1'b0, "reset enables");
    rd_chk(SCS_CTRL_ADDR, 32'h0000000f, 32'h00000001);
    rd_chk(SCS_CTRL_ADDR + 32'h4, 32'hffffffff, 32'h0);
    settle(2'h0);
    wr_reg(32'h03);
    chk(rc_en === 1'b1 && xt_en === 1'b1, "both enabled");
    rd_chk(SCS_CTRL_ADDR, 32'h18, 32'h0);
    wr_reg(32'h0b);
    settle(2'h1);
    rd_chk(SCS_CTRL_ADDR, 32'h1f, 32'h1b);
    wr_reg(32'h0a);
    chk(rc_en === 1'b0 && xt_en === 1'b1, "rc stopped");
    wr_reg(32'h0e);
    wr_reg(32'h0c);
    chk(xt_en === 1'b0, "crystal stopped");
    settle(2'h2);
    wr_reg(32'h0d);
    wr_reg(32'h05);
    settle(2'h0);
    wr_reg(32'h01);
    rd_chk(SCS_CTRL_ADDR, 32'h1f, 32'h01);
    end_sim();
  end
endmodule
`default_nettype wire
